// ===== design/trim_regs_pkg.sv
package trim_regs_pkg;

   // Streaming address space and data width
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int TRIM_W = 15;

   // Register group window covering both register groups
   localparam logic [ADDR_W-1:0] GROUP_BASE = 15'h0010;
   localparam int                SLOT_W     = 5;
   localparam int                NUM_SLOTS  = 32;

   // Register offsets
   localparam logic [ADDR_W-1:0] USER_INTERFACE_CONFIG = 15'h0010;
   localparam logic [ADDR_W-1:0] RESERVED_ANALOG_A     = 15'h0020;
   localparam logic [ADDR_W-1:0] DIGITAL_RESET_CONTROL = 15'h0021;
   localparam logic [ADDR_W-1:0] FULLSCALE_GAIN_HIGH   = 15'h0022;
   localparam logic [ADDR_W-1:0] FULLSCALE_GAIN_LOW    = 15'h0023;
   localparam logic [ADDR_W-1:0] RESERVED_ANALOG_B     = 15'h0024;
   localparam logic [ADDR_W-1:0] OFFSET_ADJUST_HIGH    = 15'h0025;
   localparam logic [ADDR_W-1:0] OFFSET_ADJUST_LOW     = 15'h0026;
   localparam logic [ADDR_W-1:0] RESERVED_ANALOG_C     = 15'h0027;
   localparam logic [ADDR_W-1:0] RESERVED_ANALOG_D     = 15'h0028;
   localparam logic [ADDR_W-1:0] RESERVED_ANALOG_E     = 15'h0029;
   localparam logic [ADDR_W-1:0] RESERVED_ANALOG_F     = 15'h002A;

   // Reset values
   localparam logic [DATA_W-1:0] RST_USER_INTERFACE_CONFIG = 8'h00;
   localparam logic [DATA_W-1:0] RST_RESERVED_ANALOG_A     = 8'h9D;
   localparam logic [DATA_W-1:0] RST_DIGITAL_RESET_CONTROL = 8'h00;
   localparam logic [DATA_W-1:0] RST_FULLSCALE_GAIN_HIGH   = 8'h40;
   localparam logic [DATA_W-1:0] RST_FULLSCALE_GAIN_LOW    = 8'h00;
   localparam logic [DATA_W-1:0] RST_RESERVED_ANALOG_B     = 8'h00;
   localparam logic [DATA_W-1:0] RST_OFFSET_ADJUST_HIGH    = 8'h40;
   localparam logic [DATA_W-1:0] RST_OFFSET_ADJUST_LOW     = 8'h00;
   localparam logic [DATA_W-1:0] RST_RESERVED_ANALOG_C     = 8'h06;
   localparam logic [DATA_W-1:0] RST_RESERVED_ANALOG_D     = 8'hBA;
   localparam logic [DATA_W-1:0] RST_RESERVED_ANALOG_E     = 8'hD4;
   localparam logic [DATA_W-1:0] RST_RESERVED_ANALOG_F     = 8'hAA;
   localparam logic [DATA_W-1:0] READ_UNMAPPED             = 8'h00;

   // Field positions
   localparam int STATIC_ADDRESS_BIT         = 0;
   localparam int EMULATED_POWERUP_RESET_BIT = 0;
   localparam int TRIM_HIGH_W                = 7;

   // Streaming address wrap points
   localparam logic [ADDR_W-1:0] ADDR_FIRST = 15'h0000;
   localparam logic [ADDR_W-1:0] ADDR_LAST  = 15'h7FFF;

   // Trim code points and analog end points
   localparam logic [TRIM_W-1:0] TRIM_CODE_MAX  = 15'h7FFF;
   localparam logic [TRIM_W-1:0] OFFSET_ZERO    = 15'h4000;
   localparam int                GAIN_MV_LOW    = 500;
   localparam int                GAIN_MV_HIGH   = 950;
   localparam int                OFFSET_MV_LOW  = -28;
   localparam int                OFFSET_MV_HIGH = 28;
   localparam int                MV_W           = 12;

   // Length of the emulated power-on reset pulse
   localparam int DEFAULT_RESET_PULSE_CYCLES = 16;

endpackage

// ===== design/trim_to_millivolt.sv
`timescale 1ns/1ps

// Linear map of a trim code onto its analog end points, in millivolts
module trim_to_millivolt #(
   parameter int MV_LOW  = 0,
   parameter int MV_HIGH = 1
) (
   input  wire logic [trim_regs_pkg::TRIM_W-1:0]      code_in,
   output logic signed [trim_regs_pkg::MV_W-1:0]      millivolt_out
);
   import trim_regs_pkg::*;

   localparam int MV_LIMIT = 2 ** (MV_W - 1);

   initial begin
      if (MV_LOW >= MV_HIGH || MV_HIGH >= MV_LIMIT || MV_LOW < -MV_LIMIT) begin
         $error("trim_to_millivolt: end points out of range");
      end
   end

   int span;
   int scaled;

   // Divide by the full code so that both end codes land exactly
   always_comb begin
      span          = MV_HIGH - MV_LOW;
      scaled        = MV_LOW + (int'(code_in) * span) / int'(TRIM_CODE_MAX);
      millivolt_out = MV_W'(scaled);
   end

endmodule

// ===== design/spi_user_gain_offset_regs.sv
`timescale 1ns/1ps

module spi_user_gain_offset_regs #(
   parameter int RESET_PULSE_CYCLES = trim_regs_pkg::DEFAULT_RESET_PULSE_CYCLES
) (
   input  wire logic                                clock_in,
   input  wire logic                                rst_in,
   input  wire logic                                access_start_in,
   input  wire logic [trim_regs_pkg::ADDR_W-1:0]    access_addr_in,
   input  wire logic                                byte_strobe_in,
   input  wire logic                                byte_write_in,
   input  wire logic [trim_regs_pkg::DATA_W-1:0]    byte_wdata_in,
   input  wire logic                                stream_direction_up_in,
   input  wire logic                                background_cal_enable_in,
   output logic      [trim_regs_pkg::ADDR_W-1:0]    byte_addr_out,
   output logic      [trim_regs_pkg::DATA_W-1:0]    byte_rdata_out,
   output logic                                     byte_rvalid_out,
   output logic                                     static_address_out,
   output logic                                     digital_reset_out,
   output logic      [trim_regs_pkg::TRIM_W-1:0]    fullscale_gain_word_out,
   output logic      [trim_regs_pkg::TRIM_W-1:0]    offset_adjust_word_out,
   output logic      [trim_regs_pkg::TRIM_W-1:0]    offset_applied_word_out,
   output logic signed [trim_regs_pkg::MV_W-1:0]    fullscale_mvpp_out,
   output logic signed [trim_regs_pkg::MV_W-1:0]    offset_mv_out
);
   import trim_regs_pkg::*;

   localparam int CNT_W = $clog2(RESET_PULSE_CYCLES + 1);

   initial begin
      if (RESET_PULSE_CYCLES < 1) begin
         $error("spi_user_gain_offset_regs: reset pulse must last a cycle");
      end
   end

   typedef enum {
      RUN,
      DIGITAL_RESET
   } reset_state_type;

   // Slot index inside the 0x010 to 0x02F window
   function automatic logic [SLOT_W-1:0] slot_of(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] rel;
      rel     = addr - GROUP_BASE;
      slot_of = rel[SLOT_W-1:0];
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      case (addr)
         USER_INTERFACE_CONFIG, RESERVED_ANALOG_A, DIGITAL_RESET_CONTROL,
         FULLSCALE_GAIN_HIGH, FULLSCALE_GAIN_LOW, RESERVED_ANALOG_B,
         OFFSET_ADJUST_HIGH, OFFSET_ADJUST_LOW, RESERVED_ANALOG_C,
         RESERVED_ANALOG_D, RESERVED_ANALOG_E, RESERVED_ANALOG_F: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] reset_value(input logic [ADDR_W-1:0] addr);
      case (addr)
         USER_INTERFACE_CONFIG: reset_value = RST_USER_INTERFACE_CONFIG;
         RESERVED_ANALOG_A:     reset_value = RST_RESERVED_ANALOG_A;
         DIGITAL_RESET_CONTROL: reset_value = RST_DIGITAL_RESET_CONTROL;
         FULLSCALE_GAIN_HIGH:   reset_value = RST_FULLSCALE_GAIN_HIGH;
         FULLSCALE_GAIN_LOW:    reset_value = RST_FULLSCALE_GAIN_LOW;
         RESERVED_ANALOG_B:     reset_value = RST_RESERVED_ANALOG_B;
         OFFSET_ADJUST_HIGH:    reset_value = RST_OFFSET_ADJUST_HIGH;
         OFFSET_ADJUST_LOW:     reset_value = RST_OFFSET_ADJUST_LOW;
         RESERVED_ANALOG_C:     reset_value = RST_RESERVED_ANALOG_C;
         RESERVED_ANALOG_D:     reset_value = RST_RESERVED_ANALOG_D;
         RESERVED_ANALOG_E:     reset_value = RST_RESERVED_ANALOG_E;
         RESERVED_ANALOG_F:     reset_value = RST_RESERVED_ANALOG_F;
         default:               reset_value = READ_UNMAPPED;
      endcase
   endfunction

   // Joins a seven-bit high register and an eight-bit low register
   function automatic logic [TRIM_W-1:0] trim_word(input logic [DATA_W-1:0] high,
                                                    input logic [DATA_W-1:0] low);
      trim_word = {high[TRIM_HIGH_W-1:0], low};
   endfunction

   logic [DATA_W-1:0]    reg_file [NUM_SLOTS];
   logic [ADDR_W-1:0]    addr_ptr;
   logic [ADDR_W-1:0]    cur_addr;
   logic [ADDR_W-1:0]    next_addr;
   logic                 access_ok;
   logic                 write_hit;
   logic                 reset_rise;
   logic                 static_address;
   logic [TRIM_W-1:0]    gain_word;
   logic [TRIM_W-1:0]    offset_word;
   logic [TRIM_W-1:0]    offset_applied;
   logic signed [MV_W-1:0] gain_mv;
   logic signed [MV_W-1:0] offset_mv;
   reset_state_type      reset_state;
   logic [CNT_W-1:0]     reset_count;

   // A start in the same cycle as a byte makes that byte use the new address
   assign cur_addr  = access_start_in ? access_addr_in : addr_ptr;
   assign access_ok = byte_strobe_in && (reset_state == RUN);
   assign write_hit = access_ok && byte_write_in && is_mapped(cur_addr);

   assign static_address = reg_file[slot_of(USER_INTERFACE_CONFIG)][STATIC_ADDRESS_BIT];

   // Only a 0 to 1 change fires; rewriting 1 over 1 does nothing
   assign reset_rise = write_hit && (cur_addr == DIGITAL_RESET_CONTROL)
      && byte_wdata_in[EMULATED_POWERUP_RESET_BIT]
      && !reg_file[slot_of(DIGITAL_RESET_CONTROL)][EMULATED_POWERUP_RESET_BIT];

   assign gain_word   = trim_word(reg_file[slot_of(FULLSCALE_GAIN_HIGH)],
                                  reg_file[slot_of(FULLSCALE_GAIN_LOW)]);
   assign offset_word = trim_word(reg_file[slot_of(OFFSET_ADJUST_HIGH)],
                                  reg_file[slot_of(OFFSET_ADJUST_LOW)]);

   // Calibration owns the offset, so the programmed code is swapped for the zero-offset code OFFSET_ZERO (15'h4000)
   assign offset_applied = background_cal_enable_in ? OFFSET_ZERO : offset_word;

   // Streaming address step
   always_comb begin
      next_addr = cur_addr;
      if (static_address) begin
         next_addr = cur_addr;
      end else if (stream_direction_up_in) begin
         next_addr = (cur_addr == ADDR_LAST) ? ADDR_FIRST : ADDR_W'(cur_addr + 1'b1);
      end else begin
         next_addr = (cur_addr == ADDR_FIRST) ? ADDR_LAST : ADDR_W'(cur_addr - 1'b1);
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         addr_ptr <= ADDR_FIRST;
      end else if (reset_state == DIGITAL_RESET) begin
         addr_ptr <= ADDR_FIRST;
      end else if (access_ok) begin
         addr_ptr <= next_addr;
      end else if (access_start_in) begin
         addr_ptr <= access_addr_in;
      end
   end

   // Register storage; the reset control byte survives its own reset pulse
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            reg_file[i] <= reset_value(ADDR_W'(GROUP_BASE + ADDR_W'(i)));
         end
      end else if (reset_state == DIGITAL_RESET) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            if (ADDR_W'(GROUP_BASE + ADDR_W'(i)) != DIGITAL_RESET_CONTROL) begin
               reg_file[i] <= reset_value(ADDR_W'(GROUP_BASE + ADDR_W'(i)));
            end
         end
      end else if (write_hit) begin
         // Reserved bits are stored as written; the host keeps them zero
         reg_file[slot_of(cur_addr)] <= byte_wdata_in;
      end
   end

   // Emulated power-on reset sequencer
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         reset_state <= RUN;
         reset_count <= '0;
      end else begin
         case (reset_state)
            RUN: begin
               if (reset_rise) begin
                  reset_state <= DIGITAL_RESET;
                  reset_count <= CNT_W'(RESET_PULSE_CYCLES - 1);
               end
            end
            DIGITAL_RESET: begin
               if (reset_count == '0) begin
                  reset_state <= RUN;
               end else begin
                  reset_count <= reset_count - 1'b1;
               end
            end
            default: begin
               reset_state <= RUN;
               reset_count <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         digital_reset_out <= 1'b0;
      end else begin
         digital_reset_out <= reset_rise
            || (reset_state == DIGITAL_RESET && reset_count != '0);
      end
   end

   // Read data; unmapped addresses answer zero and belong to other groups
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         byte_rdata_out  <= READ_UNMAPPED;
         byte_rvalid_out <= 1'b0;
         byte_addr_out   <= ADDR_FIRST;
      end else begin
         byte_rvalid_out <= access_ok && !byte_write_in;
         if (access_ok) begin
            byte_addr_out <= cur_addr;
            if (!byte_write_in) begin
               byte_rdata_out <= is_mapped(cur_addr) ? reg_file[slot_of(cur_addr)]
                                                     : READ_UNMAPPED;
            end
         end
      end
   end

   trim_to_millivolt #(
      .MV_LOW  (GAIN_MV_LOW),
      .MV_HIGH (GAIN_MV_HIGH)
   ) gain_map (
      .code_in       (gain_word),
      .millivolt_out (gain_mv)
   );

   trim_to_millivolt #(
      .MV_LOW  (OFFSET_MV_LOW),
      .MV_HIGH (OFFSET_MV_HIGH)
   ) offset_map (
      .code_in       (offset_applied),
      .millivolt_out (offset_mv)
   );

   // Trim words and their analog values, one cycle behind the registers
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         static_address_out      <= 1'b0;
         fullscale_gain_word_out <= '0;
         offset_adjust_word_out  <= '0;
         offset_applied_word_out <= '0;
         fullscale_mvpp_out      <= '0;
         offset_mv_out           <= '0;
      end else begin
         static_address_out      <= static_address;
         fullscale_gain_word_out <= gain_word;
         offset_adjust_word_out  <= offset_word;
         offset_applied_word_out <= offset_applied;
         fullscale_mvpp_out      <= gain_mv;
         offset_mv_out           <= offset_mv;
      end
   end

endmodule

// ===== testbench/trim_regs_chk.sv
`timescale 1ns/1ps
module trim_regs_chk
   import trim_regs_pkg::*;
#(
   parameter int RESET_PULSE_CYCLES = 16
) (
   input wire logic                                clock_in,
   input wire logic                                rst_in,
   input wire logic                                access_start_in,
   input wire logic                                byte_strobe_in,
   input wire logic                                byte_write_in,
   input wire logic [trim_regs_pkg::DATA_W-1:0]    byte_wdata_in,
   input wire logic                                stream_direction_up_in,
   input wire logic                                background_cal_enable_in,
   input wire logic [trim_regs_pkg::ADDR_W-1:0]    byte_addr_out,
   input wire logic                                static_address_out,
   input wire logic                                digital_reset_out,
   input wire logic [trim_regs_pkg::TRIM_W-1:0]    fullscale_gain_word_out,
   input wire logic [trim_regs_pkg::TRIM_W-1:0]    offset_adjust_word_out,
   input wire logic [trim_regs_pkg::TRIM_W-1:0]    offset_applied_word_out,
   input wire logic signed [trim_regs_pkg::MV_W-1:0] fullscale_mvpp_out
);
   logic [2:0] hush;
   int         high_cnt;
   logic       q;

   // Quiet only four edges after any reset, so refused strobes count only in the first cycle of a reset pulse
   assign q = hush == 3'h4;
   always_ff @(posedge clock_in) begin
      if (rst_in || digital_reset_out) hush <= 3'h0;
      else if (hush != 3'h4) hush <= hush + 3'h1;
   end
   always_ff @(posedge clock_in) begin
      if (rst_in || !digital_reset_out) high_cnt <= 0;
      else high_cnt <= high_cnt + 1;
   end

   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);

   chk_static_hold: assert property (q && byte_strobe_in && $past(byte_strobe_in) &&
      !access_start_in && static_address_out |=> byte_addr_out == $past(byte_addr_out))
      else $error("static address moved while streaming");
   chk_addr_step: assert property (q && byte_strobe_in && $past(byte_strobe_in) &&
      !access_start_in && !static_address_out |=> byte_addr_out == $past(byte_addr_out) +
      ($past(stream_direction_up_in, 2) ? 15'h0001 : 15'h7FFF))
      else $error("stream address step wrong");
   chk_reset_cause: assert property ($rose(digital_reset_out) |->
      $past(byte_strobe_in && byte_write_in && byte_wdata_in[0]) &&
      byte_addr_out == DIGITAL_RESET_CONTROL) else $error("reset pulse without its write");
   chk_pulse_len: assert property ($fell(digital_reset_out) |->
      high_cnt == RESET_PULSE_CYCLES) else $error("reset pulse length wrong");
   chk_gain_map: assert property (q && $stable(fullscale_gain_word_out) |->
      int'(fullscale_mvpp_out) == 500 + int'(fullscale_gain_word_out) * 450 / 32767)
      else $error("gain millivolts wrong");
   chk_cal_ignore: assert property (q && $stable(background_cal_enable_in) &&
      $stable(offset_adjust_word_out) |-> offset_applied_word_out ==
      (background_cal_enable_in ? OFFSET_ZERO : offset_adjust_word_out))
      else $error("applied offset wrong");
   chk_gain_cause: assert property (q && $changed(fullscale_gain_word_out) |->
      $past(byte_strobe_in && byte_write_in, 2) && ($past(byte_addr_out) ==
      FULLSCALE_GAIN_HIGH || $past(byte_addr_out) == FULLSCALE_GAIN_LOW))
      else $error("gain word changed without a write");
   chk_offset_cause: assert property (q && $changed(offset_adjust_word_out) |->
      $past(byte_strobe_in && byte_write_in, 2) && ($past(byte_addr_out) ==
      OFFSET_ADJUST_HIGH || $past(byte_addr_out) == OFFSET_ADJUST_LOW))
      else $error("offset word changed without a write");

   cover property (q && byte_strobe_in && static_address_out);
   cover property ($rose(digital_reset_out));
   cover property (q && background_cal_enable_in && $changed(offset_adjust_word_out));
endmodule

bind spi_user_gain_offset_regs trim_regs_chk #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) chk (.*);

// ===== testbench/cfg_host.sv
`timescale 1ns/1ps
module cfg_host
   import trim_regs_pkg::*;
(
   input  wire logic                             clock_in,
   output logic                                  start_out,
   output logic [trim_regs_pkg::ADDR_W-1:0]      addr_out,
   output logic                                  strobe_out,
   output logic                                  write_out,
   output logic [trim_regs_pkg::DATA_W-1:0]      wdata_out
);
   initial begin
      start_out = 1'b0;
      addr_out = '0;
      strobe_out = 1'b0;
      write_out = 1'b0;
      wdata_out = '0;
   end
   // Strobe is left up so calls can follow each other every cycle
   task automatic xfer(input logic st, input logic [ADDR_W-1:0] a, input logic wr,
                       input logic [DATA_W-1:0] d);
      @(posedge clock_in);
      start_out <= st;
      addr_out <= a;
      strobe_out <= 1'b1;
      write_out <= wr;
      wdata_out <= (st && (a == FULLSCALE_GAIN_HIGH || a == OFFSET_ADJUST_HIGH)) ?
                   {1'b0, d[6:0]} : d;
   endtask
   task automatic idle();
      @(posedge clock_in);
      start_out <= 1'b0;
      strobe_out <= 1'b0;
      addr_out <= ~addr_out;
      wdata_out <= ~wdata_out;
   endtask
endmodule

// ===== testbench/spi_user_gain_offset_regs_tb.sv
`timescale 1ns/1ps
module spi_user_gain_offset_regs_tb;
   import trim_regs_pkg::*;
   localparam int PULSE = 4;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic dir_up = 1'b1;
   logic cal_on = 1'b0;
   logic start, strobe, wr, rvalid, stat, dres;
   logic [ADDR_W-1:0] addr, baddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [TRIM_W-1:0] gword, oword, oapp, code;
   logic signed [MV_W-1:0] gmv, omv;
   int errors = 0;
   int checks_done = 0;
   int seed = 50372;
   int n;
   logic [7:0] rst_vals [12] = '{8'h00, 8'h9D, 8'h00, 8'h40, 8'h00, 8'h00, 8'h40, 8'h00,
                                 8'h06, 8'hBA, 8'hD4, 8'hAA};
   logic [TRIM_W-1:0] ends [3] = '{15'h0000, 15'h4000, 15'h7FFF};
   int gain_ends [3] = '{500, 725, 950};
   int off_ends [3] = '{-28, 0, 28};

   always #10 clock_in = ~clock_in;

   spi_user_gain_offset_regs #(.RESET_PULSE_CYCLES(PULSE)) uut (
      .clock_in(clock_in), .rst_in(rst_in), .access_start_in(start),
      .access_addr_in(addr), .byte_strobe_in(strobe), .byte_write_in(wr),
      .byte_wdata_in(wdata), .stream_direction_up_in(dir_up),
      .background_cal_enable_in(cal_on), .byte_addr_out(baddr), .byte_rdata_out(rdata),
      .byte_rvalid_out(rvalid), .static_address_out(stat), .digital_reset_out(dres),
      .fullscale_gain_word_out(gword), .offset_adjust_word_out(oword),
      .offset_applied_word_out(oapp), .fullscale_mvpp_out(gmv), .offset_mv_out(omv));
   cfg_host host (.clock_in(clock_in), .start_out(start), .addr_out(addr),
                  .strobe_out(strobe), .write_out(wr), .wdata_out(wdata));

   function automatic int gain_mv(input logic [TRIM_W-1:0] c);
      return 500 + int'(c) * 450 / 32767;
   endfunction
   function automatic int off_mv(input logic [TRIM_W-1:0] c);
      return -28 + int'(c) * 56 / 32767;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      host.xfer(1'b1, a, 1'b0, 8'h00);
      host.idle();
      #1;
      check(rvalid, 1'b1);
      check(rdata, exp);
   endtask
   task automatic wrt(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      host.xfer(1'b1, a, 1'b1, d);
      host.idle();
   endtask
   task automatic stream(input logic up, input logic [ADDR_W-1:0] a, input logic hold);
      logic [ADDR_W-1:0] exp;
      exp = a;
      host.xfer(1'b1, a, 1'b0, 8'h00);
      dir_up <= up;
      for (int i = 0; i < 4; i++) begin
         host.xfer(1'b0, a, 1'b0, 8'h00);
         #1;
         check(baddr, exp);
         if (i == 0) check(stat, hold);
         if (!hold) exp = up ? exp + 15'h0001 : exp - 15'h0001;
      end
      host.idle();
   endtask

   initial begin
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      #1;
      check(stat, 1'b0);
      check(gmv, 725);
      check(omv, 0);
      for (int i = 0; i < 12; i++) rd(i == 0 ? 15'h0010 : 15'(31 + i), rst_vals[i]);
      wrt(15'h002B, 8'h5A);
      rd(15'h002B, READ_UNMAPPED);
      for (int i = 0; i < 8; i++) begin
         code = i < 3 ? ends[i] : 15'($random(seed));
         wrt(FULLSCALE_GAIN_HIGH, {1'b0, code[14:8]});
         wrt(FULLSCALE_GAIN_LOW, code[7:0]);
         wrt(OFFSET_ADJUST_HIGH, {1'b0, code[14:8]});
         wrt(OFFSET_ADJUST_LOW, code[7:0]);
         cal_on <= i > 4;
         repeat (3) @(posedge clock_in);
         #1;
         check(gword, code);
         check(gmv, gain_mv(code));
         check(oword, code);
         check(oapp, cal_on ? OFFSET_ZERO : code);
         check(omv, cal_on ? 0 : off_mv(code));
         if (i < 3 || cal_on) check(omv, cal_on ? 0 : off_ends[i]);
         if (i < 3) check(gmv, gain_ends[i]);
      end
      stream(1'b1, 15'h7FFE, 1'b0);
      stream(1'b0, 15'h0001, 1'b0);
      wrt(USER_INTERFACE_CONFIG, 8'h01);
      stream(1'b1, OFFSET_ADJUST_HIGH, 1'b1);
      wrt(USER_INTERFACE_CONFIG, 8'h00);
      for (int k = 0; k < 3; k++) begin
         if (k == 2) wrt(DIGITAL_RESET_CONTROL, 8'h00);
         wrt(FULLSCALE_GAIN_LOW, 8'h3C);
         wrt(DIGITAL_RESET_CONTROL, 8'h01);
         #1;
         n = 0;
         while (dres === 1'b1 && n < 50) begin
            @(posedge clock_in);
            #1;
            n++;
         end
         if (n == 50) begin
            check(n, PULSE);
            end_of_test();
         end
         check(n, k == 1 ? 0 : PULSE);
         repeat (2) @(posedge clock_in);
         rd(DIGITAL_RESET_CONTROL, 8'h01);
         rd(FULLSCALE_GAIN_LOW, k == 1 ? 8'h3C : 8'h00);
      end
      end_of_test();
   end
endmodule
